// ### design/pipelined_burst_sram_port.v
// Function
// - address taken only on a strobe edge with all chip selects active.
// - low two address bits seed the burst counter on every new address.
// - lane selects, sampled at the edge, write only with the qualifier low.
// - all-lane write low writes every lane, ignoring selects and qualifier.
// - advance low during a burst steps the counter each edge.
// - processor strobe ignored while primary chip select is high.
// - chip selects sampled only on new address edges, not continuation.
// - selected when primary low, second high, third low.
// - without third select input, treat it as always active.
// - output enable low drives data pins, high floats them.
// - first clock of read after deselect keeps outputs off.
// - processor strobe low captures address and loads counter bits.
// - controller strobe low captures address and loads counter bits.
// - both strobes low: processor strobe alone acts while primary select is low.
// - sleep high enters low-activity state, contents kept.
// - sleep input defaults low, normal operation when low or open.
// - order strap low gives linear, high or open interleaved order.
// - read data leave output registers one clock after address edge.
// - burst counter wraps inside its four-address window.
`timescale 1ns/1ps
`include "burst_sram_regs.vh"

module pipelined_burst_sram_port #(
   parameter HAS_THIRD_SEL = 1 // 0 for the two-select variant
) (
   input wire ref_clk, // 10 MHz system clock
   input wire rst_n, // synchronous reset, active low
   input wire [`SRAM_UPPER_W-1:0] upperAddr, // word address above bit 1
   input wire [1:0] burst_start_bits, // low two address bits
   input wire processor_addr_strobe_n, // processor strobe, low
   input wire controller_addr_strobe_n, // controller strobe, low
   input wire burst_advance_n, // burst advance, low
   input wire all_lane_write_n, // write every lane, low
   input wire lane_write_qualify_n, // lane write qualifier, low
   input wire [`SRAM_LANES-1:0] lane_write_select_n, // lane selects, low
   input wire chip_sel_primary_n, // primary chip select, low
   input wire chip_sel_second_high, // second chip select, high
   input wire chip_sel_third_n, // third chip select, low
   input wire outEnable_n, // asynchronous output enable, low
   input wire sleep_request, // asynchronous sleep request, high
   input wire burstOrderStrap, // static order strap, low is linear
   input wire [`SRAM_DATA_W-1:0] dqIn, // data pins as seen on the wire
   output wire [`SRAM_DATA_W-1:0] dqOut, // read data toward the pins
   output wire dqOe, // data pin drive enable, high drives
   output wire sleepActive, // device is in sleep
   output wire selectedState, // a selected burst is open
   output wire [1:0] accessBits // low bits of the last access
);

// asynchronous pins: three flops, change accepted when last two agree
localparam [2:0] SYNC_INIT = `SYNC_RST;
wire [2:0] asyncIn;
wire [2:0] filtBits;

assign asyncIn = {burstOrderStrap, sleep_request, outEnable_n};

genvar g;
generate
   for (g = 0; g < 3; g = g + 1) begin : syncPin
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg filt_reg;
      always @(posedge ref_clk) begin
         if (!rst_n) begin
            s1_reg <= SYNC_INIT[g];
            s2_reg <= SYNC_INIT[g];
            s3_reg <= SYNC_INIT[g];
            filt_reg <= SYNC_INIT[g];
         end else begin
            s1_reg <= asyncIn[g];
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
               filt_reg <= s3_reg;
            end
         end
      end
      assign filtBits[g] = filt_reg;
   end
endgenerate

wire oeLow;
wire sleepOn;
wire linearMode;

assign oeLow = !filtBits[`SYNC_BIT_OE];
// idle value of sleep is low, so reset leaves normal operation
assign sleepOn = filtBits[`SYNC_BIT_SLEEP];
assign linearMode = (filtBits[`SYNC_BIT_ORDER] == `ORDER_LINEAR);

// port state, one-hot: deselected, burst open, asleep
localparam [2:0] ST_IDLE = `RST_STATE;
localparam [2:0] ST_OPEN = 3'h2;
localparam [2:0] ST_SLEEP = 3'h4;
reg [2:0] state_reg;
reg [2:0] state_next;
wire burstOpen;

assign burstOpen = state_reg[`ST_BIT_OPEN];

// data path state
reg [`SRAM_UPPER_W-1:0] base_reg;
reg [`SRAM_UPPER_W-1:0] base_next;
reg readStage_reg;
reg readStage_next;
reg [`SRAM_DATA_W-1:0] dqOut_reg;
reg [`SRAM_DATA_W-1:0] dqOut_next;
reg dqOe_reg;
reg dqOe_next;
reg [1:0] access_reg;
reg [1:0] access_next;

// chip select decode
wire thirdOk;
wire chipSelected;

assign thirdOk = (HAS_THIRD_SEL == 0) ? 1'b1 : !chip_sel_third_n;
assign chipSelected = !chip_sel_primary_n && chip_sel_second_high
   && thirdOk;

// strobe decode
wire procStart;
wire ctrlStart;
wire newAddr;
wire startSel;
wire contCycle;
wire stepNow;

assign procStart = !sleepOn && !processor_addr_strobe_n
   && !chip_sel_primary_n;
assign ctrlStart = !sleepOn && !controller_addr_strobe_n && !procStart;
assign newAddr = procStart || ctrlStart;
assign startSel = newAddr && chipSelected;
assign contCycle = !newAddr && burstOpen && !sleepOn;
assign stepNow = contCycle && !burst_advance_n;

// burst counter
wire [1:0] curBits;
wire [1:0] nextBits;

burst_counter u_counter (
   .ref_clk(ref_clk),
   .rst_n(rst_n),
   .load(startSel),
   .seed(burst_start_bits),
   .step(stepNow),
   .linear(linearMode),
   .curBits(curBits),
   .nextBits(nextBits)
);

// address of this edge's access
wire [1:0] lowBits;
wire [`SRAM_ADDR_W-1:0] memAddr;

assign lowBits = startSel ? burst_start_bits
   : (stepNow ? nextBits : curBits);
assign memAddr = {(startSel ? upperAddr : base_reg), lowBits};

// write decode
reg [`SRAM_LANES-1:0] laneMask;

always @* begin
   laneMask = `LANES_NONE;
   if (!all_lane_write_n) begin
      laneMask = `LANES_ALL;
   end else if (!lane_write_qualify_n) begin
      laneMask = ~lane_write_select_n;
   end
end

// a processor-strobe start is always a read; writes follow in the burst
wire writeEdge;
wire doWrite;
wire doRead;
wire [`SRAM_LANES-1:0] memWe;

assign writeEdge = (ctrlStart && chipSelected) || contCycle;
assign doWrite = writeEdge && (laneMask != `LANES_NONE);
assign doRead = (procStart && chipSelected) || (writeEdge && !doWrite);
assign memWe = doWrite ? laneMask : `LANES_NONE;

// storage; sleep blocks every access, so contents stay put
// no access in sleep
wire [`SRAM_DATA_W-1:0] memRd;

sram_lane_array u_array (
   .ref_clk(ref_clk),
   .addr(memAddr),
   .wrLanes(memWe),
   .wrData(dqIn),
   .rdData(memRd)
);

// first clock of a read straight out of deselect
wire firstClk;

assign firstClk = startSel && doRead && !burstOpen;

// port state: deselected, burst open or asleep
always @* begin
   state_next = state_reg;
   case (state_reg)
      ST_IDLE: begin
         if (sleepOn) begin
            state_next = ST_SLEEP;
         end else if (startSel) begin
            state_next = ST_OPEN;
         end
      end
      ST_OPEN: begin
         if (sleepOn) begin
            state_next = ST_SLEEP;
         // a strobe with selects off is a deselect
         end else if (newAddr && !chipSelected) begin
            state_next = ST_IDLE;
         end
      end
      ST_SLEEP: begin
         // wake counts as deselected, so no stale burst resumes
         if (!sleepOn) begin
            state_next = startSel ? ST_OPEN : ST_IDLE;
         end
      end
      default: begin
         state_next = ST_IDLE;
      end
   endcase
end

// next state
always @* begin
   base_next = base_reg;
   readStage_next = doRead;
   dqOut_next = dqOut_reg;
   dqOe_next = 1'b0;
   access_next = access_reg;
   if (startSel) begin
      base_next = upperAddr;
   end
   if (startSel || contCycle) begin
      access_next = lowBits;
   end
   if (readStage_reg) begin
      dqOut_next = memRd;
   end
   // mask first read clock
   // pins stay off outside read data, so no fight with write data
   if (oeLow && readStage_reg && !firstClk && !sleepOn) begin
      dqOe_next = 1'b1;
   end
end

always @(posedge ref_clk) begin
   if (!rst_n) begin
      state_reg <= `RST_STATE;
      base_reg <= `RST_UPPER;
      readStage_reg <= `RST_FLAG;
      dqOut_reg <= `RST_DATA;
      dqOe_reg <= `RST_FLAG;
      access_reg <= `RST_BITS2;
   end else begin
      state_reg <= state_next;
      base_reg <= base_next;
      readStage_reg <= readStage_next;
      dqOut_reg <= dqOut_next;
      dqOe_reg <= dqOe_next;
      access_reg <= access_next;
   end
end

assign dqOut = dqOut_reg;
assign dqOe = dqOe_reg;
assign sleepActive = state_reg[`ST_BIT_SLEEP];
assign selectedState = state_reg[`ST_BIT_OPEN];
assign accessBits = access_reg;

endmodule // pipelined_burst_sram_port

// ### design/burst_sram_regs.vh
`ifndef BURST_SRAM_REGS_VH
`define BURST_SRAM_REGS_VH

// word and lane geometry of the wide organisation
`define SRAM_ADDR_W 18
`define SRAM_UPPER_W 16
`define SRAM_DATA_W 36
`define SRAM_LANE_W 9
`define SRAM_LANES 4

// field positions of the two burst start bits in a full word address
`define START_BIT_LO 0
`define START_BIT_HI 1

// reset values
`define RST_BITS2 2'h0
`define RST_UPPER 16'h0000
`define RST_DATA 36'h0_0000_0000
`define RST_LANES 4'h0
`define RST_FLAG 1'h0

// one-hot port state: reset code and flag bit positions
`define RST_STATE 3'h1
`define ST_BIT_OPEN 1
`define ST_BIT_SLEEP 2

// synchroniser idle values: {order strap, sleep, output enable}
`define SYNC_RST 3'h5
`define SYNC_BIT_OE 0
`define SYNC_BIT_SLEEP 1
`define SYNC_BIT_ORDER 2

// lane write patterns and burst order coding
`define LANES_ALL 4'hf
`define LANES_NONE 4'h0
`define ORDER_LINEAR 1'h0
`define BURST_STEP 2'h1

`endif

// ### design/burst_counter.v
`timescale 1ns/1ps
`include "burst_sram_regs.vh"

module burst_counter (
   input wire ref_clk, // system clock
   input wire rst_n, // synchronous reset, active low
   input wire load, // new external address taken
   input wire [1:0] seed, // low address bits of the new address
   input wire step, // advance one beat
   input wire linear, // 1 linear order, 0 interleaved
   output wire [1:0] curBits, // low bits of the current beat
   output wire [1:0] nextBits // low bits of the following beat
);

reg [1:0] start_reg;
reg [1:0] count_reg;
reg [1:0] start_next;
reg [1:0] count_next;
wire [1:0] countPlus;

assign countPlus = count_reg + `BURST_STEP;

assign curBits = linear ? start_reg + count_reg : start_reg ^ count_reg;
assign nextBits = linear ? start_reg + countPlus : start_reg ^ countPlus;

always @* begin
   start_next = start_reg;
   count_next = count_reg;
   if (load) begin
      start_next = seed;
      count_next = `RST_BITS2;
   end else if (step) begin
      count_next = countPlus;
   end
end

always @(posedge ref_clk) begin
   if (!rst_n) begin
      start_reg <= `RST_BITS2;
      count_reg <= `RST_BITS2;
   end else begin
      start_reg <= start_next;
      count_reg <= count_next;
   end
end

endmodule // burst_counter

// ### design/sram_lane_array.v
`timescale 1ns/1ps
`include "burst_sram_regs.vh"

module sram_lane_array (
   input wire ref_clk, // system clock
   input wire [`SRAM_ADDR_W-1:0] addr, // word address of this edge
   input wire [`SRAM_LANES-1:0] wrLanes, // per lane write strobes
   input wire [`SRAM_DATA_W-1:0] wrData, // write data
   output wire [`SRAM_DATA_W-1:0] rdData // registered read data
);

localparam DEPTH = 1 << `SRAM_ADDR_W;

genvar i;
generate
   for (i = 0; i < `SRAM_LANES; i = i + 1) begin : lane
      reg [`SRAM_LANE_W-1:0] laneMem [0:DEPTH-1];
      reg [`SRAM_LANE_W-1:0] rd_reg;
      // contents carry no reset, so sleep and reset keep them
      always @(posedge ref_clk) begin
         if (wrLanes[i]) begin
            laneMem[addr] <= wrData[i*`SRAM_LANE_W +: `SRAM_LANE_W];
         end
         rd_reg <= laneMem[addr];
      end
      assign rdData[i*`SRAM_LANE_W +: `SRAM_LANE_W] = rd_reg;
   end
endgenerate

endmodule // sram_lane_array

// ### verification/sram_port_monitor.sv
`timescale 1ns/1ps
module sram_port_monitor #(
   parameter HAS_THIRD_SEL = 1 // 0: two selects
) (
   input wire ref_clk, // clock
   input wire rst_n, // reset
   input wire [1:0] burst_start_bits, // low bits
   input wire processor_addr_strobe_n, // strobe
   input wire controller_addr_strobe_n, // strobe
   input wire burst_advance_n, // advance
   input wire chip_sel_primary_n, // select
   input wire chip_sel_second_high, // select
   input wire chip_sel_third_n, // select
   input wire burstOrderStrap, // order
   input wire dqOe, // drive
   input wire sleepActive, // sleep
   input wire selectedState, // open
   input wire [1:0] accessBits // beat
);
   wire selOk = !chip_sel_primary_n && chip_sel_second_high &&
      (!chip_sel_third_n || HAS_THIRD_SEL == 0);
   wire pGo = !processor_addr_strobe_n && !chip_sel_primary_n;
   wire cGo = !controller_addr_strobe_n && !pGo;
   wire cont = !pGo && controller_addr_strobe_n && selectedState;
   default clocking @(posedge ref_clk); endclocking
   reset_clear_a:
   assert property (!rst_n |=> !dqOe && !sleepActive && !selectedState
      && accessBits == 2'h0) else $error("reset state wrong");
   proc_load_a:
   assert property (disable iff (!rst_n) pGo && selOk && !sleepActive |=>
      sleepActive || (selectedState && accessBits == $past(burst_start_bits)))
      else $error("processor address not taken");
   ctrl_load_a:
   assert property (disable iff (!rst_n) cGo && selOk && !sleepActive |=>
      sleepActive || (selectedState && accessBits == $past(burst_start_bits)))
      else $error("controller address not taken");
   deselect_close_a:
   assert property (disable iff (!rst_n) (pGo || cGo) && !selOk
      |=> !selectedState) else $error("unselected start opened burst");
   burst_hold_a:
   assert property (disable iff (!rst_n) cont && burst_advance_n &&
      !sleepActive |=> sleepActive || (selectedState && $stable(accessBits)))
      else $error("burst moved without advance");
   linear_step_a:
   assert property (disable iff (!rst_n) cont && !burst_advance_n &&
      !sleepActive && !burstOrderStrap && !$past(burstOrderStrap, 4) |=>
      sleepActive || accessBits == $past(accessBits) + 2'h1)
      else $error("linear step wrong");
   first_read_off_a:
   assert property (disable iff (!rst_n) !selectedState && (pGo || cGo)
      && selOk |=> !dqOe) else $error("drive in first read period");
   sleep_block_a:
   assert property (disable iff (!rst_n) sleepActive [*2] |-> !selectedState)
      else $error("burst open in sleep");
endmodule // sram_port_monitor

// ### verification/sram_host_side.sv
`timescale 1ns/1ps
module sram_host_side (
   input wire ref_clk, // clock
   input wire [35:0] dqOut, // device data
   input wire dqOe, // device drives
   input wire [35:0] hostData, // write data
   input wire hostDrive, // host drives
   output wire [35:0] dqWire // pin level
);
   reg [35:0] lastReg = 36'h0;
   // released bus never holds a value
   assign dqWire = dqOe ? dqOut : hostDrive ? hostData : ~lastReg;
   always @(posedge ref_clk) begin
      lastReg <= dqWire;
   end
endmodule // sram_host_side

// ### verification/tb_pipelined_burst_sram_port.sv
`timescale 1ns/1ps
module tb_pipelined_burst_sram_port;
   localparam [2:0] SEL = 3'h2;
   reg ref_clk = 0, rst_n = 0, procStb_n = 1, ctrlStb_n = 1, adv_n = 1;
   reg allWr_n = 1, qual_n = 1, cs1_n = 0, cs2 = 1, cs3_n = 0, oe_n = 0;
   reg zz = 0, strap = 1, hostDrive = 0;
   reg [3:0] lane_n = 4'hf;
   reg [17:0] addr = 18'h0_0000;
   reg [35:0] hostData = 36'h0, mem [0:3];
   wire [35:0] dqOut, dqWire;
   wire [1:0] accessBits;
   wire dqOe, sleepActive, selectedState, selTwo;
   int error_cnt = 0, checks = 0, i;
   pipelined_burst_sram_port pipelined_burst_sram_port_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .upperAddr(addr[17:2]),
      .burst_start_bits(addr[1:0]), .processor_addr_strobe_n(procStb_n),
      .controller_addr_strobe_n(ctrlStb_n), .burst_advance_n(adv_n),
      .all_lane_write_n(allWr_n), .lane_write_qualify_n(qual_n),
      .lane_write_select_n(lane_n), .chip_sel_primary_n(cs1_n),
      .chip_sel_second_high(cs2), .chip_sel_third_n(cs3_n),
      .outEnable_n(oe_n), .sleep_request(zz), .burstOrderStrap(strap),
      .dqIn(dqWire), .dqOut(dqOut), .dqOe(dqOe), .sleepActive(sleepActive),
      .selectedState(selectedState), .accessBits(accessBits));
   // two-select variant on the same pins
   pipelined_burst_sram_port #(.HAS_THIRD_SEL(0))
      pipelined_burst_sram_port_two_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .upperAddr(addr[17:2]),
      .burst_start_bits(addr[1:0]), .processor_addr_strobe_n(procStb_n),
      .controller_addr_strobe_n(ctrlStb_n), .burst_advance_n(adv_n),
      .all_lane_write_n(allWr_n), .lane_write_qualify_n(qual_n),
      .lane_write_select_n(lane_n), .chip_sel_primary_n(cs1_n),
      .chip_sel_second_high(cs2), .chip_sel_third_n(cs3_n),
      .outEnable_n(oe_n), .sleep_request(zz), .burstOrderStrap(strap),
      .dqIn(dqWire), .dqOut(), .dqOe(), .sleepActive(),
      .selectedState(selTwo), .accessBits());
   sram_host_side sram_host_side_inst (.ref_clk(ref_clk), .dqOut(dqOut),
      .dqOe(dqOe), .hostData(hostData), .hostDrive(hostDrive),
      .dqWire(dqWire));
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic cmpData(input [35:0] got, input [35:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmpBits(input [1:0] got, input [1:0] exp);
      cmpData({34'h0, got}, {34'h0, exp});
   endtask
   function automatic [35:0] merge(input [35:0] old, input [35:0] d,
      input gw, input q, input [3:0] ln);
      merge = old;
      for (int j = 0; j < 4; j++)
         if (!gw || (!q && !ln[j])) merge[9*j +: 9] = d[9*j +: 9];
   endfunction
   function automatic [1:0] order(input [1:0] s, input [1:0] k, input lin);
      order = lin ? s + k : s ^ k;
   endfunction
   task automatic drive(input p, input c, input a, input gw, input q,
      input [3:0] ln, input [2:0] cs, input [1:0] lo, input [35:0] d);
      @(posedge ref_clk);
      procStb_n <= p;
      ctrlStb_n <= c;
      adv_n <= a;
      allWr_n <= gw;
      qual_n <= q;
      lane_n <= ln;
      {cs1_n, cs2, cs3_n} <= cs;
      addr[1:0] <= lo;
      hostData <= d;
      hostDrive <= !gw || !q;
   endtask
   task automatic nop();
      drive(1, 1, 1, 1, 1, 4'hf, SEL, 2'h0, 36'h0);
   endtask
   task automatic wr(input p, input [1:0] lo, input gw, input q,
      input [3:0] ln);
      reg [35:0] d;
      d = 36'({$urandom, $urandom});
      drive(p, 0, 1, gw, q, ln, SEL, lo, d);
      // processor strobe wins and never writes
      if (p) mem[lo] = merge(mem[lo], d, gw, q, ln);
   endtask
   task automatic rd(input [1:0] lo, input cold);
      drive(1, 0, 1, 1, 1, 4'hf, SEL, lo, 36'h0);
      nop();
      #1 cmpBits(accessBits, lo);
      if (cold) cmpBits(dqOe, 0);
      nop();
      #1 cmpData(dqOut, mem[lo]);
      cmpBits(dqOe, !oe_n);
   endtask
   task automatic burst(input [1:0] s, input p, input lin);
      drive(p, !p, 1, 1, 1, 4'hf, SEL, s, 36'h0);
      for (int k = 0; k < 6; k++) begin
         drive(1, 1, 0, 1, 1, 4'hf, 3'($urandom), s, 36'h0);
         #1 cmpBits(accessBits, order(s, 2'(k), lin));
         if (k > 0) cmpData(dqOut, mem[order(s, 2'(k - 1), lin)]);
      end
   endtask
   task automatic test_done();
      $display("error_cnt %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #(100 * 3000);
      error_cnt++;
      test_done();
   end
   initial begin
      void'($urandom(32'h5f92_3c7c));
      @(posedge ref_clk);
      addr[17:2] <= 16'($urandom);
      repeat (15) @(posedge ref_clk);
      rst_n <= 1;
      repeat (4) nop();
      for (i = 0; i < 4; i++) wr(1, 2'(i), 0, 1, 4'h0);
      // lane 0 always picked: an empty mask would read and fight the host
      repeat (16)
         wr(1, 2'($urandom), 1'($urandom), 0, 4'($urandom) & 4'he);
      repeat (4) wr(1, 2'($urandom), 1, 1, 4'h0);
      wr(0, 2'h2, 0, 0, 4'h0);
      drive(1, 0, 1, 1, 1, 4'hf, 3'h6, 2'h0, 36'h0);
      rd(2'h0, 1);
      for (i = 1; i < 4; i++) rd(2'(i), 0);
      drive(0, 1, 1, 1, 1, 4'hf, 3'h6, 2'h1, 36'h0);
      nop();
      #1 cmpBits(accessBits, 2'h3);
      burst(2'h1, 0, 0);
      for (i = 0; i < 8; i++) begin
         drive(1, 0, 1, 1, 1, 4'hf, 3'(i), 2'h1, 36'h0);
         nop();
         #1 cmpBits(selectedState, i == 2);
         cmpBits(selTwo, i == 2 || i == 3);
      end
      @(posedge ref_clk);
      zz <= 1;
      repeat (8) nop();
      drive(1, 0, 1, 1, 1, 4'hf, SEL, 2'h1, 36'h0);
      nop();
      #1 cmpBits(sleepActive, 1);
      cmpBits(selectedState, 0);
      @(posedge ref_clk);
      zz <= 0;
      oe_n <= 1;
      repeat (8) nop();
      #1 cmpBits(sleepActive, 0);
      rd(2'h3, 0);
      @(posedge ref_clk);
      oe_n <= 0;
      strap <= 0;
      repeat (8) nop();
      burst(2'h3, 1, 1);
      test_done();
   end
endmodule // tb_pipelined_burst_sram_port
bind pipelined_burst_sram_port sram_port_monitor #(
   .HAS_THIRD_SEL(HAS_THIRD_SEL)) sram_port_monitor_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .burst_start_bits(burst_start_bits),
   .processor_addr_strobe_n(processor_addr_strobe_n),
   .controller_addr_strobe_n(controller_addr_strobe_n),
   .burst_advance_n(burst_advance_n), .chip_sel_primary_n(chip_sel_primary_n),
   .chip_sel_second_high(chip_sel_second_high),
   .chip_sel_third_n(chip_sel_third_n), .burstOrderStrap(burstOrderStrap),
   .dqOe(dqOe), .sleepActive(sleepActive), .selectedState(selectedState),
   .accessBits(accessBits));
